//--- pms_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// link and device port checks
// ----------------------------------------------------------------
module pms_chk
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic wr_strobe,
  input wire logic [7:0] wr_data,
  input wire logic wait_pulse,
  input wire logic [7:0] ctrl_status,
  input wire logic wake_event,
  input wire logic fast_osc_stable,
  input wire logic slow_crystal_input,
  input wire logic fast_osc_stop,
  input wire pms_pkg::pms_mode_t power_mode
);
  import pms_pkg::*;
  logic xtal_seen; // slow crystal seen since reset

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  // sticky crystal flag
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      xtal_seen <= 1'b0;
    else if (slow_crystal_input)
      xtal_seen <= 1'b1;
  end

  property p_res; ctrl_status[4] == 1'b0; endproperty
  a_res: assert property (p_res) else $error("reserved bit set");
  property p_defer; wr_strobe |-> ##2 ctrl_status[5] == $past(wr_data[5], 2); endproperty
  a_defer: assert property (p_defer) else $error("defer bit not loaded");
  property p_idle; wait_pulse && power_mode == PMS_ACTIVE && ctrl_status[5] && ctrl_status[2]
    && !ctrl_status[3] && ctrl_status[7] && !wake_event |-> ##2 power_mode == PMS_IDLE; endproperty
  a_idle: assert property (p_idle) else $error("idle not entered");
  property p_halt; wait_pulse && power_mode == PMS_ACTIVE && ctrl_status[5] && ctrl_status[3]
    && !wake_event |-> ##2 power_mode == PMS_HALT; endproperty
  a_halt: assert property (p_halt) else $error("halt not entered");
  property p_refuse; wait_pulse && power_mode == PMS_ACTIVE && !ctrl_status[5] && !ctrl_status[0]
    |=> ##1 power_mode == PMS_ACTIVE; endproperty
  a_refuse: assert property (p_refuse) else $error("wait without defer left active");
  property p_stop_late; $rose(fast_osc_stop) |-> power_mode != PMS_ACTIVE
    && $past(power_mode) != PMS_ACTIVE; endproperty
  a_stop_late: assert property (p_stop_late) else $error("fast clock stopped early");
  property p_act_run; power_mode == PMS_ACTIVE |-> !fast_osc_stop; endproperty
  a_act_run: assert property (p_act_run) else $error("fast clock off in active");
  property p_no_xtal; fast_osc_stop |-> power_mode == PMS_HALT || xtal_seen; endproperty
  a_no_xtal: assert property (p_no_xtal) else $error("fast clock off without crystal");
  property p_wake_clr; wake_event && power_mode != PMS_ACTIVE |-> ##[1:6] ctrl_status[3:0] == 4'h0;
  endproperty
  a_wake_clr: assert property (p_wake_clr) else $error("wake left mode bits");
  property p_wake_act; wake_event && fast_osc_stable && power_mode != PMS_ACTIVE
    |-> ##[1:12] power_mode == PMS_ACTIVE; endproperty
  a_wake_act: assert property (p_wake_act) else $error("wake did not reach active");
  property p_good; $rose(power_mode == PMS_ACTIVE) |-> $past(fast_osc_stable, 2); endproperty
  a_good: assert property (p_good) else $error("active without stable clock");
endmodule
`default_nettype wire

//--- pms_cpu_end.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// cpu end: wishbone slave toward software, link toward device
// ----------------------------------------------------------------
module pms_cpu_end
  import pms_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic [pms_pkg::WB_ADR_W-1:0] wb_adr_i,
  input wire logic [pms_pkg::WB_DAT_W-1:0] wb_dat_i,
  output logic [pms_pkg::WB_DAT_W-1:0] wb_dat_o,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  input wire logic cpu_wait,
  pms_if.cpu link
);
  import pms_pkg::*;

  logic req; // request pending, not yet answered
  logic wr_take; // write taken at this edge

  // address match on a word
  function automatic logic hit(input logic [WB_ADR_W-1:0] adr, input logic [WB_ADR_W-1:0] reg_adr);
    hit = (adr == reg_adr);
  endfunction

  // ----------------------------------------------------------------
  // bus handshake
  // ----------------------------------------------------------------
  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_take = wb_ack_o & wb_we_i & wb_sel_i[0];

  // one wait state, ack for one cycle
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= req;
  end

  // read data, unmapped reads zero
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      wb_dat_o <= 32'h0000_0000;
    else if (req && !wb_we_i && hit(wb_adr_i, REG_CTRL_STATUS))
      wb_dat_o <= {24'h00_0000, link.ctrl_status};
    else if (req)
      wb_dat_o <= 32'h0000_0000;
  end

  // ----------------------------------------------------------------
  // link drive
  // ----------------------------------------------------------------
  // write byte held from the request, stable at ack
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      link.wr_data <= CTRL_RESET;
    else if (req)
      link.wr_data <= wb_dat_i[7:0];
  end

  // write to the device when the master sees ack
  assign link.wr_strobe = wr_take & hit(wb_adr_i, REG_CTRL_STATUS);
  // wait from the cpu core or from software
  assign link.wait_pulse = cpu_wait | (wr_take & hit(wb_adr_i, REG_WAIT));

endmodule
`default_nettype wire

//--- pms_device.sv
// Overview of operation
// - idle bit plus wait enters idle
// - idle only from active/psave, active needs defer
// - halt bit plus wait enters halt similarly
// - fast clock stops only after low mode
// - psave runs slow; fast-off write stops fast
// - fast osc on in active, off halt
// - software awaits slow good before psave
// - psave clear reads zero after active reached
// - software reenables fast, waits good, exits
// - wake clears fast-off, awaits good, active
// - status bits show running stable clocks
// - mode switch waits for needed clock good
// - no slow crystal: fast stops only halt
// - no crystal: exits use fast, psave divided
// - slow crystal input held low means absent
// - no crystal: slow clock divides fast clock
// - defer bit picks immediate or wait timing
// - wake clears psave, idle, halt bits
// - reset clears control bits, starts active
`timescale 1ns/1ps
`default_nettype none
module pms_device
  import pms_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  pms_if.dev link,
  input wire logic wake_event,
  input wire logic fast_osc_stable,
  input wire logic slow_osc_stable,
  input wire logic slow_crystal_input,
  output logic fast_osc_stop,
  output logic cpu_on_slow_clock,
  output pms_pkg::pms_mode_t power_mode,
  output logic slow_system_clock
);
  import pms_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [3:0] sync_a; // first synchroniser stage
  logic [3:0] sync_b; // second synchroniser stage
  logic wake_s; // synchronised wake event
  logic fast_stable_s; // synchronised fast oscillator stable
  logic slow_stable_s; // synchronised slow oscillator stable
  logic crystal_s; // synchronised slow crystal input
  logic crystal_present; // slow crystal input seen high since reset
  logic [7:0] div_count; // slow clock divider count
  logic slow_div_clock; // divided fast clock
  pms_mode_t mode; // current power mode
  pms_mode_t next_mode; // mode for next cycle
  logic waking; // wake seen, waiting for fast clock
  logic wait_seen; // wait event held while clock not ready
  logic psm_bit; // power_save_select as read back
  logic psm_target; // software wants power save
  logic fast_off_req; // fast_osc_off_request
  logic idle_req; // idle request bit
  logic halt_req; // halt request bit
  logic defer; // defer_low_power_to_wait
  logic fast_good; // fast_clock_good
  logic slow_good; // slow_clock_good
  logic wake_hit; // wake accepted in a low-power mode
  logic low_mode; // power save or idle
  logic next_fast_stop; // oscillator stop for next cycle

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  // two flops on every asynchronous input
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      sync_a <= 4'h0;
      sync_b <= 4'h0;
    end
    else
    begin
      sync_a <= {slow_crystal_input, slow_osc_stable, fast_osc_stable, wake_event};
      sync_b <= sync_a;
    end
  end

  assign wake_s = sync_b[0];
  assign fast_stable_s = sync_b[1];
  assign slow_stable_s = sync_b[2];
  assign crystal_s = sync_b[3];

  // ----------------------------------------------------------------
  // slow crystal detection and slow clock
  // ----------------------------------------------------------------
  // a tied-low input never rises, so the crystal stays absent
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      crystal_present <= 1'b0;
    else if (crystal_s)
      crystal_present <= 1'b1;
  end

  // divided fast clock, used when no crystal is fitted
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      div_count <= 8'h00;
      slow_div_clock <= 1'b0;
    end
    else if (div_count == SLOW_DIV_LAST)
    begin
      div_count <= 8'h00;
      slow_div_clock <= ~slow_div_clock;
    end
    else
      div_count <= div_count + 8'h01;
  end

  // slow clock source select, registered
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      slow_system_clock <= 1'b0;
    else
      slow_system_clock <= crystal_present ? crystal_s : slow_div_clock;
  end

  // ----------------------------------------------------------------
  // clock status
  // ----------------------------------------------------------------
  // fast clock good only while running and reported stable
  assign fast_good = fast_stable_s & ~fast_osc_stop;
  // prescaled slow clock is always good
  assign slow_good = crystal_present ? slow_stable_s : 1'b1;
  assign low_mode = (mode == PMS_PSAVE) || (mode == PMS_IDLE);
  assign wake_hit = wake_s && (mode != PMS_ACTIVE);

  // ----------------------------------------------------------------
  // mode transitions
  // ----------------------------------------------------------------
  always_comb
  begin
    next_mode = mode;
    if (waking)
    begin
      // wake goes straight to active once fast clock good
      if (fast_good)
        next_mode = PMS_ACTIVE;
    end
    else
    begin
      unique case (mode)
        PMS_ACTIVE:
        begin
          // idle and halt need defer set before the wait
          if (wait_seen && defer && halt_req)
            next_mode = PMS_HALT;
          else if (wait_seen && defer && idle_req && slow_good)
            next_mode = PMS_IDLE;
          else if (psm_target && (!defer || wait_seen) && slow_good)
            next_mode = PMS_PSAVE;
        end
        PMS_PSAVE:
        begin
          if (wait_seen && halt_req)
            next_mode = PMS_HALT;
          else if (wait_seen && idle_req && slow_good)
            next_mode = PMS_IDLE;
          else if (!psm_target && fast_good)
            next_mode = PMS_ACTIVE;
        end
        PMS_IDLE:
          next_mode = PMS_IDLE; // left only by wake
        PMS_HALT:
          next_mode = PMS_HALT; // left only by wake
      endcase
    end
  end

  // mode register, starts active
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      mode <= PMS_ACTIVE;
    else
      mode <= next_mode;
  end

  // wake in progress until active reached
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      waking <= 1'b0;
    else if (wake_hit)
      waking <= 1'b1;
    else if (mode == PMS_ACTIVE)
      waking <= 1'b0;
  end

  // wait event kept only while a clock holds the switch off
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      wait_seen <= 1'b0;
    else if (wake_hit || (next_mode != mode))
      wait_seen <= 1'b0;
    else
      wait_seen <= link.wait_pulse | (wait_seen & ~slow_good);
  end

  // ----------------------------------------------------------------
  // control bits
  // ----------------------------------------------------------------
  // wake clearing wins over a write in the same cycle
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      fast_off_req <= 1'b0;
      idle_req <= 1'b0;
      halt_req <= 1'b0;
      defer <= 1'b0;
      psm_target <= 1'b0;
    end
    else if (wake_hit)
    begin
      fast_off_req <= 1'b0;
      idle_req <= 1'b0;
      halt_req <= 1'b0;
      psm_target <= 1'b0;
    end
    else if (link.wr_strobe)
    begin
      fast_off_req <= link.wr_data[BIT_FAST_OFF];
      idle_req <= link.wr_data[BIT_IDLE];
      halt_req <= link.wr_data[BIT_HALT];
      defer <= link.wr_data[BIT_DEFER];
      psm_target <= link.wr_data[BIT_POWER_SAVE];
    end
  end

  // power save bit as software sees it
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      psm_bit <= 1'b0;
    else if (wake_hit)
      psm_bit <= 1'b0;
    else if (link.wr_strobe && (mode == PMS_ACTIVE))
      // deferred request reads one at once, else on arrival
      psm_bit <= link.wr_data[BIT_POWER_SAVE] & link.wr_data[BIT_DEFER];
    else if ((mode != PMS_PSAVE) && (next_mode == PMS_PSAVE))
      psm_bit <= 1'b1;
    else if ((mode == PMS_PSAVE) && (next_mode == PMS_ACTIVE))
      psm_bit <= 1'b0;
  end

  // ----------------------------------------------------------------
  // oscillator control
  // ----------------------------------------------------------------
  always_comb
  begin
    // halt stops unless waking, active never; low modes only with a crystal
    next_fast_stop = 1'b0;
    if (!waking)
    begin
      if (mode == PMS_HALT)
        next_fast_stop = 1'b1;
      else if (low_mode && fast_off_req && crystal_present)
        next_fast_stop = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      fast_osc_stop <= 1'b0;
    else
      fast_osc_stop <= next_fast_stop;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // cpu runs from slow clock outside active
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      cpu_on_slow_clock <= 1'b0;
    else
      cpu_on_slow_clock <= (next_mode != PMS_ACTIVE);
  end

  assign power_mode = mode;

  // status byte, reserved bit reads zero
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      link.ctrl_status <= CTRL_RESET;
    else
    begin
      link.ctrl_status <= 8'h00;
      link.ctrl_status[BIT_POWER_SAVE] <= psm_bit;
      link.ctrl_status[BIT_FAST_OFF] <= fast_off_req;
      link.ctrl_status[BIT_IDLE] <= idle_req;
      link.ctrl_status[BIT_HALT] <= halt_req;
      link.ctrl_status[BIT_DEFER] <= defer;
      link.ctrl_status[BIT_FAST_GOOD] <= fast_good;
      link.ctrl_status[BIT_SLOW_GOOD] <= slow_good;
    end
  end

endmodule
`default_nettype wire

//--- pms_if.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// link between the cpu end and the power mode device
// ----------------------------------------------------------------
interface pms_if;
  logic wr_strobe; // one-cycle write of the control byte
  logic [7:0] wr_data; // control byte being written
  logic wait_pulse; // one-cycle wait instruction event
  logic [7:0] ctrl_status; // control/status byte read back

  // device end
  modport dev (
    input wr_strobe,
    input wr_data,
    input wait_pulse,
    output ctrl_status
  );

  // cpu end
  modport cpu (
    output wr_strobe,
    output wr_data,
    output wait_pulse,
    input ctrl_status
  );
endinterface
`default_nettype wire

//--- pms_pkg.sv
// ----------------------------------------------------------------
// power mode switch constants
// ----------------------------------------------------------------
package pms_pkg;

  // control/status byte layout
  localparam int unsigned CTRL_WIDTH = 8; // width of the control/status byte
  localparam int unsigned BIT_POWER_SAVE = 0; // power_save_select
  localparam int unsigned BIT_FAST_OFF = 1; // fast_osc_off_request
  localparam int unsigned BIT_IDLE = 2; // idle request
  localparam int unsigned BIT_HALT = 3; // halt request
  localparam int unsigned BIT_DEFER = 5; // defer_low_power_to_wait
  localparam int unsigned BIT_FAST_GOOD = 6; // fast_clock_good, read only
  localparam int unsigned BIT_SLOW_GOOD = 7; // slow_clock_good, read only
  localparam logic [7:0] CTRL_RESET = 8'h00; // all control bits clear

  // wishbone map, byte addresses
  localparam int unsigned WB_ADR_W = 4; // address width
  localparam int unsigned WB_DAT_W = 32; // data width
  localparam logic [3:0] REG_CTRL_STATUS = 4'h0; // power_mode_ctrl_status
  localparam logic [3:0] REG_WAIT = 4'h4; // write: issue a wait event

  // slow clock divider: fast clock divided by 512
  localparam logic [7:0] SLOW_DIV_LAST = 8'hff; // half period minus one

  // power modes
  typedef enum logic [1:0] {
    PMS_ACTIVE,
    PMS_PSAVE,
    PMS_IDLE,
    PMS_HALT
  } pms_mode_t;

endpackage

//--- tb_power_mode_switch_control.sv
`timescale 1ns/1ps
`default_nettype none
module tb_power_mode_switch_control;
  import pms_pkg::*;
  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  logic clock = 1'b0; // 4 ns clock
  logic rstn = 1'b0; // reset, active low
  logic [3:0] adr = 4'h0; // bus address
  logic [31:0] wdat = 32'h0; // bus write data
  logic [31:0] rdat; // bus read data
  logic [3:0] sel = 4'h0; // byte lanes
  logic we = 1'b0, cyc = 1'b0, stb = 1'b0, ack; // bus control
  logic cpu_wait = 1'b0, wake = 1'b0; // wait and wake events
  logic fast_ok = 1'b1, slow_ok = 1'b1, xtal = 1'b0; // oscillator side
  logic stop, on_slow, slow_clk; // device outputs
  pms_mode_t mode; // current mode
  logic [7:0] tab [4] = '{8'h26, 8'h28, 8'h21, 8'h23}; // entry requests
  int err_total = 0;
  int n_tests = 0;
  pms_if link ();
  pms_cpu_end u_pms_cpu_end (.clock(clock), .rstn(rstn), .wb_adr_i(adr), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_ack_o(ack), .cpu_wait(cpu_wait), .link(link));
  pms_device u_pms_device (.clock(clock), .rstn(rstn), .link(link), .wake_event(wake),
    .fast_osc_stable(fast_ok), .slow_osc_stable(slow_ok), .slow_crystal_input(xtal),
    .fast_osc_stop(stop), .cpu_on_slow_clock(on_slow), .power_mode(mode),
    .slow_system_clock(slow_clk));
  pms_chk u_pms_chk (.clock(clock), .rstn(rstn), .wr_strobe(link.wr_strobe),
    .wr_data(link.wr_data), .wait_pulse(link.wait_pulse), .ctrl_status(link.ctrl_status),
    .wake_event(wake), .fast_osc_stable(fast_ok), .slow_crystal_input(xtal),
    .fast_osc_stop(stop), .power_mode(mode));

  always #2 clock = ~clock;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one classic cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d,
    output logic [31:0] q);
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    sel <= 4'hf;
    @(posedge clock);
    while (ack !== 1'b1)
      @(posedge clock);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  // wait event from the cpu pin or the bus
  task automatic pulse_wait(input bit via_bus);
    logic [31:0] q;
    if (via_bus)
      wb(1'b1, REG_WAIT, 8'h01, q);
    else
    begin
      @(posedge clock);
      cpu_wait <= 1'b1;
      @(posedge clock);
      cpu_wait <= 1'b0;
    end
  endtask

  task automatic wait_mode(input pms_mode_t m);
    int n;
    n = 0;
    while (mode !== m && n < 300)
    begin
      @(posedge clock);
      n++;
    end
    chk({30'h0, mode}, {30'h0, m});
  endtask

  // halt beats idle beats power save
  function automatic pms_mode_t exp_mode(input logic [7:0] c);
    if (c[BIT_HALT])
      return PMS_HALT;
    if (c[BIT_IDLE])
      return PMS_IDLE;
    return PMS_PSAVE;
  endfunction

  // fast clock stops in halt, or on request when a crystal exists
  function automatic logic exp_stop(input logic [7:0] c, input logic x);
    return c[BIT_HALT] | (c[BIT_FAST_OFF] & x);
  endfunction

  task automatic report_and_stop;
    $display("checks %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // watchdog
  // ----------------------------------------------------------------
  initial
  begin
    repeat (30000) @(posedge clock);
    err_total++;
    report_and_stop;
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    logic [31:0] q;
    logic [7:0] c;
    logic prev;
    int cnt;
    void'($urandom(24727));
    repeat (12) @(posedge clock);
    rstn <= 1'b1;
    repeat (6) @(posedge clock);
    wb(1'b0, REG_CTRL_STATUS, 8'h00, q);
    chk(q, 32'hc0);
    wb(1'b0, 4'h8, 8'h00, q);
    chk(q, 32'h0);
    wb(1'b1, 4'hc, 8'h28, q);
    wb(1'b0, REG_CTRL_STATUS, 8'h00, q);
    chk(q, 32'hc0);
    // divided clock: 512 cycles a period
    cnt = 0;
    prev = slow_clk;
    repeat (1024)
    begin
      @(posedge clock);
      if (slow_clk !== prev)
        cnt++;
      prev = slow_clk;
    end
    chk(cnt, 4);
    for (int x = 0; x < 2; x++)
    begin
      xtal <= x[0];
      repeat (8) @(posedge clock);
      foreach (tab[i])
      begin
        c = tab[i];
        wb(1'b1, REG_CTRL_STATUS, c, q);
        wb(1'b0, REG_CTRL_STATUS, 8'h00, q);
        chk(q & 32'h3f, {24'h0, c & 8'h3f});
        pulse_wait($urandom_range(1));
        wait_mode(exp_mode(c));
        repeat (3) @(posedge clock);
        chk(stop, exp_stop(c, x[0]));
        chk(on_slow, 1'b1);
        if (c == 8'h21)
        begin
          wb(1'b1, REG_CTRL_STATUS, 8'h20, q);
          wait_mode(PMS_ACTIVE);
          wb(1'b0, REG_CTRL_STATUS, 8'h00, q);
          chk(q & 32'h01, 32'h0);
        end
        else
        begin
          fast_ok <= 1'b0;
          wake <= 1'b1;
          repeat ($urandom_range(15)) @(posedge clock);
          chk(mode == PMS_ACTIVE, 1'b0);
          fast_ok <= 1'b1;
          wait_mode(PMS_ACTIVE);
          chk(stop, 1'b0);
          wake <= 1'b0;
          wb(1'b0, REG_CTRL_STATUS, 8'h00, q);
          chk(q & 32'h4f, 32'h40);
        end
      end
    end
    // immediate power save with fast clock off, then software-led return
    wb(1'b1, REG_CTRL_STATUS, 8'h03, q);
    wait_mode(PMS_PSAVE);
    repeat (3) @(posedge clock);
    chk(stop, 1'b1);
    wb(1'b1, REG_CTRL_STATUS, 8'h01, q);
    cnt = 0;
    q = 32'h0;
    while (q[BIT_FAST_GOOD] !== 1'b1 && cnt < 50)
    begin
      wb(1'b0, REG_CTRL_STATUS, 8'h00, q);
      cnt++;
    end
    chk(q & 32'h41, 32'h41);
    wb(1'b1, REG_CTRL_STATUS, 8'h00, q);
    wait_mode(PMS_ACTIVE);
    // idle request without defer is refused in active
    wb(1'b1, REG_CTRL_STATUS, 8'h04, q);
    pulse_wait(1'b0);
    repeat (4) @(posedge clock);
    chk({30'h0, mode}, {30'h0, PMS_ACTIVE});
    report_and_stop;
  end
endmodule
`default_nettype wire
